// ==== ncmo_host.sv ====
// Host controller sequencing command, address and data cycles to the flash
`timescale 1ns/100ps
module ncmo_host (
  // Clock, reset, enable
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  en_i,
  // Software register port
  input  wire logic [7:0]            addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [31:0]           rdata_o,
  // Flash pins
  input  wire ncmo_pkg::ncmo_pin_in_s pin_i,
  output ncmo_pkg::ncmo_pins_s        pins_o
);

  localparam int BLK_L = ncmo_pkg::BLK_LSB;

  ncmo_pkg::ncmo_state_e st_q, st_d;
  ncmo_pkg::ncmo_pins_s  pins_d;
  logic [1:0]                      kind_q;
  logic [2:0]                      idx_q;
  logic [2:0]                      last_q;
  logic [4:0]                      cnt_q;
  logic [7:0]                      byte_q;
  logic [7:0]                      dout_q;
  logic [7:0]                      lcmd_q;
  logic [ncmo_pkg::COL_W-1:0]      col_q;
  logic [ncmo_pkg::ROW_W-1:0]      row_q;
  logic [ncmo_pkg::ROW_W-1:0]      mr_row_q;
  logic [ncmo_pkg::ROW_W-1:BLK_L]  cblk_q;
  logic                            settle_q;
  logic                            cache_q;
  logic                            guard_q;
  logic                            mr_first_q;
  logic                            mr_pair_q;
  logic [1:0]                      cfg_q;
  logic [3:0]                      err_q;

  function automatic logic no_wait(input logic [7:0] c);
    no_wait = (c == ncmo_pkg::C_STATUS) || (c == ncmo_pkg::C_STATUS_M) || (c == ncmo_pkg::C_RESET);
  endfunction : no_wait

  function automatic logic makes_busy(input logic [7:0] c);
    makes_busy = (c == ncmo_pkg::C_READ_GO) || (c == ncmo_pkg::C_CACHE_RD) || (c == ncmo_pkg::C_CACHE_LS) ||
                 (c == ncmo_pkg::C_PROG) || (c == ncmo_pkg::C_PROG_CA) || (c == ncmo_pkg::C_PROG_D0) ||
                 (c == ncmo_pkg::C_ERASE) || (c == ncmo_pkg::C_RESET);
  endfunction : makes_busy

  function automatic logic [7:0] addr_byte(input logic [2:0] i, input logic [12:0] c, input logic [16:0] r);
    case (i)
      3'h0:    addr_byte = c[7:0];
      3'h1:    addr_byte = {3'h0, c[12:8]};
      3'h2:    addr_byte = r[7:0];
      3'h3:    addr_byte = r[15:8];
      default: addr_byte = {7'h00, r[16]};
    endcase
  endfunction : addr_byte

  // Request decode
  wire        idle     = (st_q == ncmo_pkg::S_IDLE);
  wire        w_cmd    = wr_i && (addr_i == ncmo_pkg::REG_CMD);
  wire        w_go     = wr_i && (addr_i == ncmo_pkg::REG_GO) && (wdata_i[1:0] != 2'h0);
  wire        w_din    = wr_i && (addr_i == ncmo_pkg::REG_DATA);
  wire        w_stat   = wr_i && (addr_i == ncmo_pkg::REG_STAT);
  wire        w_cfg    = wr_i && (addr_i == ncmo_pkg::REG_CFG);
  wire        w_col    = wr_i && (addr_i == ncmo_pkg::REG_COL) && idle;
  wire        w_row    = wr_i && (addr_i == ncmo_pkg::REG_ROW) && idle;
  wire [7:0]  cbyte    = wdata_i[7:0];
  wire        go_adr5  = w_go && (wdata_i[1:0] == ncmo_pkg::GO_ADR5);
  wire        go_adr2  = w_go && (wdata_i[1:0] == ncmo_pkg::GO_ADR2);
  wire        go_read  = w_go && (wdata_i[1:0] == ncmo_pkg::GO_READ);
  wire        req      = w_cmd || w_go || w_din;
  wire        err_busy = req && !idle;
  wire        cmd_bad  = guard_q && !no_wait(cbyte) && (cbyte != ncmo_pkg::C_DIN_D1);
  wire        blk_bad  = cache_q && (row_q[ncmo_pkg::ROW_W-1:BLK_L] != cblk_q);
  wire        in_mr    = (lcmd_q == ncmo_pkg::C_MREAD) && mr_first_q && !mr_pair_q;
  wire        same_dis = row_q[BLK_L] == mr_row_q[BLK_L];
  wire        page_dif = row_q[ncmo_pkg::PAGE_W-1:0] != mr_row_q[ncmo_pkg::PAGE_W-1:0];
  wire        dist_bad = in_mr && (same_dis || page_dif);
  wire        err_seq  = idle && w_cmd && cmd_bad;
  wire        err_blk  = idle && go_adr5 && blk_bad;
  wire        err_dist = idle && go_adr5 && !blk_bad && dist_bad;
  wire        acc_cmd  = idle && w_cmd && !cmd_bad;
  wire        acc_adr5 = idle && go_adr5 && !blk_bad && !dist_bad;
  wire        acc_adr2 = idle && go_adr2;
  wire        acc_rd   = idle && go_read;
  wire        acc_din  = idle && w_din;
  wire        start    = acc_cmd || acc_adr5 || acc_adr2 || acc_rd || acc_din;
  wire        cnt_end  = (cnt_q == 5'h00);
  wire        last_one = (idx_q == last_q);
  wire [3:0]  err_set  = {err_dist, err_blk, err_seq, err_busy};
  wire [1:0]  kind_d   = acc_cmd ? ncmo_pkg::K_CMD : (acc_adr5 || acc_adr2) ? ncmo_pkg::K_ADR :
                         acc_rd ? ncmo_pkg::K_DOUT : ncmo_pkg::K_DIN;
  wire [2:0]  last_d   = acc_adr5 ? 3'(ncmo_pkg::ADR5_N - 1) : acc_adr2 ? 3'(ncmo_pkg::ADR2_N - 1) : 3'h0;
  wire        strobe   = (st_q == ncmo_pkg::S_LOW) || (st_q == ncmo_pkg::S_HIGH);
  wire [7:0]  obyte    = (kind_q == ncmo_pkg::K_ADR) ? addr_byte(idx_q, col_q, row_q) : byte_q;
  wire [31:0] stat_w   = {20'h00000, err_q, 2'h0, mr_pair_q, mr_first_q, guard_q, cache_q, pin_i.rb, !idle};

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ncmo_pkg::S_IDLE:   if (start) st_d = (acc_cmd && !no_wait(cbyte)) ? ncmo_pkg::S_WAIT : ncmo_pkg::S_LOW;
      ncmo_pkg::S_WAIT:   if (pin_i.rb) st_d = ncmo_pkg::S_LOW;
      ncmo_pkg::S_LOW:    if (cnt_end) st_d = ncmo_pkg::S_HIGH;
      ncmo_pkg::S_HIGH:   if (cnt_end) st_d = !last_one ? ncmo_pkg::S_LOW : settle_q ? ncmo_pkg::S_SETTLE : ncmo_pkg::S_IDLE;
      ncmo_pkg::S_SETTLE: if (cnt_end) st_d = ncmo_pkg::S_IDLE;
      default:            st_d = ncmo_pkg::S_IDLE;
    endcase
  end

  // Pin drive, strobes high outside a bus cycle
  always_comb begin
    pins_d         = '0;
    pins_d.ce_n    = !cfg_q[1];
    pins_d.cle     = strobe && (kind_q == ncmo_pkg::K_CMD);
    pins_d.ale     = strobe && (kind_q == ncmo_pkg::K_ADR);
    pins_d.we_n    = !((st_q == ncmo_pkg::S_LOW) && (kind_q != ncmo_pkg::K_DOUT));
    pins_d.re_n    = !((st_q == ncmo_pkg::S_LOW) && (kind_q == ncmo_pkg::K_DOUT));
    pins_d.wp_n    = cfg_q[0] || mr_first_q;
    pins_d.io      = obyte;
    pins_d.io_oe_n = !(strobe && (kind_q != ncmo_pkg::K_DOUT));
  end

  // Sequencer registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q     <= ncmo_pkg::S_IDLE;
      kind_q   <= ncmo_pkg::K_CMD;
      idx_q    <= 3'h0;
      last_q   <= 3'h0;
      cnt_q    <= 5'h00;
      byte_q   <= 8'h00;
      settle_q <= 1'b0;
    end else if (en_i) begin
      st_q <= st_d;
      if (start) begin
        kind_q   <= kind_d;
        last_q   <= last_d;
        idx_q    <= 3'h0;
        byte_q   <= cbyte;
        settle_q <= acc_cmd && makes_busy(cbyte);
      end
      if (st_d != st_q) begin
        cnt_q <= (st_d == ncmo_pkg::S_LOW) ? ncmo_pkg::LO_CYC - 5'h01 :
                 (st_d == ncmo_pkg::S_HIGH) ? ncmo_pkg::HI_CYC - 5'h01 : ncmo_pkg::SETTLE_CYC - 5'h01;
      end else if (!cnt_end) begin
        cnt_q <= cnt_q - 5'h01;
      end
      if ((st_q == ncmo_pkg::S_HIGH) && cnt_end && !last_one) idx_q <= idx_q + 3'h1;
    end
  end

  // Captured data, pins and read port
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dout_q  <= 8'h00;
      rdata_o <= 32'h00000000;
      pins_o  <= '{ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1, io_oe_n: 1'b1, default: '0};
    end else if (en_i) begin
      pins_o <= pins_d;
      if ((st_q == ncmo_pkg::S_LOW) && cnt_end && (kind_q == ncmo_pkg::K_DOUT)) dout_q <= pin_i.io;
      if (!rd_i) rdata_o <= 32'h00000000;
      else if (addr_i == ncmo_pkg::REG_COL) rdata_o <= {19'h00000, col_q};
      else if (addr_i == ncmo_pkg::REG_ROW) rdata_o <= {15'h0000, row_q};
      else if (addr_i == ncmo_pkg::REG_DATA) rdata_o <= {24'h000000, dout_q};
      else if (addr_i == ncmo_pkg::REG_STAT) rdata_o <= stat_w;
      else if (addr_i == ncmo_pkg::REG_CFG) rdata_o <= {30'h00000000, cfg_q};
      else rdata_o <= 32'h00000000;
    end
  end

  // Address, configuration and error flags
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      col_q <= '0;
      row_q <= '0;
      cfg_q <= ncmo_pkg::CFG_RST;
      err_q <= 4'h0;
    end else if (en_i) begin
      if (w_col) col_q <= wdata_i[ncmo_pkg::COL_W-1:0];
      if (w_row) row_q <= wdata_i[ncmo_pkg::ROW_W-1:0];
      if (w_cfg) cfg_q <= wdata_i[1:0];
      err_q <= (err_q & ~(w_stat ? wdata_i[11:8] : 4'h0)) | err_set;
    end
  end

  // Sequence tracking flags
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lcmd_q     <= 8'h00;
      cache_q    <= 1'b0;
      cblk_q     <= '0;
      guard_q    <= 1'b0;
      mr_first_q <= 1'b0;
      mr_pair_q  <= 1'b0;
      mr_row_q   <= '0;
    end else if (en_i) begin
      if (acc_cmd) begin
        lcmd_q <= cbyte;
        if ((cbyte == ncmo_pkg::C_CACHE_RD) || (cbyte == ncmo_pkg::C_PROG_CA)) cache_q <= 1'b1;
        else if ((cbyte == ncmo_pkg::C_CACHE_LS) || (cbyte == ncmo_pkg::C_PROG) ||
                 (cbyte == ncmo_pkg::C_RESET)) cache_q <= 1'b0;
        if (cbyte == ncmo_pkg::C_PROG_D0) guard_q <= 1'b1;
        else if ((cbyte == ncmo_pkg::C_DIN_D1) || (cbyte == ncmo_pkg::C_RESET)) guard_q <= 1'b0;
        if ((cbyte == ncmo_pkg::C_READ_GO) || (cbyte == ncmo_pkg::C_ERASE) || (cbyte == ncmo_pkg::C_RESET)) begin
          mr_first_q <= 1'b0;
          mr_pair_q  <= 1'b0;
        end
      end
      if (acc_adr5) begin
        cblk_q <= row_q[ncmo_pkg::ROW_W-1:BLK_L];
        if ((lcmd_q == ncmo_pkg::C_MREAD) && !mr_first_q) begin
          mr_first_q <= 1'b1;
          mr_row_q   <= row_q;
        end else if (in_mr) begin
          mr_pair_q <= 1'b1;
        end
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  logic [2:0] abytes_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) abytes_q <= 3'h0;
    else if (en_i && start) abytes_q <= 3'h0;
    else if (en_i && (st_q == ncmo_pkg::S_LOW) && cnt_end && (kind_q == ncmo_pkg::K_ADR)) abytes_q <= abytes_q + 3'h1;
  end

  strobe_excl_a: assert property (!(!pins_o.we_n && !pins_o.re_n)) else $error("both strobes low");
  ready_wait_a: assert property ((st_q == ncmo_pkg::S_WAIT) && !pin_i.rb && en_i |=>
                                 st_q == ncmo_pkg::S_WAIT) else $error("command issued while busy");
  addr_count_a: assert property (en_i && (st_q == ncmo_pkg::S_HIGH) && cnt_end && last_one &&
                                 (kind_q == ncmo_pkg::K_ADR) |-> abytes_q == last_q + 3'h1)
                  else $error("wrong address cycle count");
  guard_block_a: assert property (en_i && idle && w_cmd && cmd_bad |=>
                                  err_q[1] && idle) else $error("forbidden command not refused");
  block_change_a: assert property (en_i && err_blk |=> err_q[2] && idle && !start)
                    else $error("block change not refused");
  district_pair_a: assert property (en_i && idle && go_adr5 && !blk_bad && in_mr && (same_dis || page_dif) |=>
                                    err_q[3] && idle)
                     else $error("bad district pair accepted");
  wp_held_a: assert property (mr_first_q && $past(mr_first_q) |-> pins_o.wp_n)
               else $error("write protect low in multi read");
  settle_wait_a: assert property (en_i && (st_q == ncmo_pkg::S_HIGH) && cnt_end && last_one && settle_q |=>
                                  (st_q == ncmo_pkg::S_SETTLE)[*2]) else $error("busy settle skipped");
  read_port_a: assert property (rd_i && en_i && (addr_i == ncmo_pkg::REG_STAT) |=> rdata_o[0] == $past(!idle))
                 else $error("status read mismatch");

  mr_pair_c: cover property (acc_adr5 && in_mr);
  cache_rd_c: cover property (acc_cmd && (cbyte == ncmo_pkg::C_CACHE_RD));
  guard_c: cover property (guard_q && acc_cmd && (cbyte == ncmo_pkg::C_DIN_D1));
  read_c: cover property ((kind_q == ncmo_pkg::K_DOUT) && !pins_o.re_n);

endmodule : ncmo_host

// ==== ncmo_pkg.sv ====
// Constants, types and register map for the NAND sequencing host controller
package ncmo_pkg;

  // Clock and pin timing
  localparam int         CLK_NS         = 5;
  localparam int         STROBE_LO_NS   = 15;
  localparam int         STROBE_HI_NS   = 10;
  localparam int         BUSY_SETTLE_NS = 100;
  localparam logic [4:0] LO_CYC         = 5'((STROBE_LO_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] HI_CYC         = 5'((STROBE_HI_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] SETTLE_CYC     = 5'((BUSY_SETTLE_NS + CLK_NS - 1) / CLK_NS);

  // Register offsets
  localparam logic [7:0] REG_CMD  = 8'h00;
  localparam logic [7:0] REG_COL  = 8'h04;
  localparam logic [7:0] REG_ROW  = 8'h08;
  localparam logic [7:0] REG_GO   = 8'h0c;
  localparam logic [7:0] REG_DATA = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_CFG  = 8'h18;
  localparam logic [1:0] CFG_RST  = 2'h0;

  // Operation codes written to the go register
  localparam logic [1:0] GO_ADR5 = 2'h1;
  localparam logic [1:0] GO_ADR2 = 2'h2;
  localparam logic [1:0] GO_READ = 2'h3;

  // Bus cycle kinds
  localparam logic [1:0] K_CMD  = 2'h0;
  localparam logic [1:0] K_ADR  = 2'h1;
  localparam logic [1:0] K_DIN  = 2'h2;
  localparam logic [1:0] K_DOUT = 2'h3;

  // Device command bytes
  localparam logic [7:0] C_READ_GO  = 8'h30;
  localparam logic [7:0] C_CACHE_RD = 8'h31;
  localparam logic [7:0] C_CACHE_LS = 8'h3f;
  localparam logic [7:0] C_PROG     = 8'h10;
  localparam logic [7:0] C_PROG_CA  = 8'h15;
  localparam logic [7:0] C_PROG_D0  = 8'h11;
  localparam logic [7:0] C_DIN_D1   = 8'h81;
  localparam logic [7:0] C_MREAD    = 8'h60;
  localparam logic [7:0] C_ERASE    = 8'hd0;
  localparam logic [7:0] C_STATUS   = 8'h70;
  localparam logic [7:0] C_STATUS_M = 8'h71;
  localparam logic [7:0] C_RESET    = 8'hff;

  // Address layout
  localparam int COL_W   = 13;
  localparam int ROW_W   = 17;
  localparam int PAGE_W  = 6;
  localparam int BLK_LSB = 6;
  localparam int ADR5_N  = 5;
  localparam int ADR2_N  = 2;

  typedef enum logic [4:0] {
    S_IDLE   = 5'h01,
    S_WAIT   = 5'h02,
    S_LOW    = 5'h04,
    S_HIGH   = 5'h08,
    S_SETTLE = 5'h10
  } ncmo_state_e;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic       wp_n;
    logic [7:0] io;
    logic       io_oe_n;
  } ncmo_pins_s;

  typedef struct packed {
    logic [7:0] io;
    logic       rb;
  } ncmo_pin_in_s;

endpackage : ncmo_pkg

// ==== ncmo_flash_model.sv ====
// Behavioural flash device facing the host controller
`timescale 1ns/100ps
module ncmo_flash_model (
  // Clock and pins
  input  wire logic                 sys_clk_i,
  input  wire ncmo_pkg::ncmo_pins_s pins_i,
  // Scenario controls
  input  wire logic                 fail_i,
  input  wire logic                 slow_i,
  // Pins back to host
  output ncmo_pkg::ncmo_pin_in_s    pin_o
);
  logic [7:0]  mem_q [16];
  logic [7:0]  dout_q;
  logic [7:0]  lo_q;
  logic [39:0] adr_q;
  logic [12:0] col_q;
  logic [1:0]  pf_q;
  logic        stat_q;
  int          busy_q;
  int          n_q;
  wire         rdy    = (busy_q == 0);
  wire  [7:0]  stat_w = {pins_i.wp_n, rdy, rdy, 3'h0, pf_q};
  initial begin
    {dout_q, lo_q, adr_q, col_q, pf_q, stat_q} = '0;
    busy_q = 0;
    n_q = 0;
  end
  // Open drain line reads high when released
  assign pin_o.rb = rdy;
  assign pin_o.io = (!pins_i.ce_n && !pins_i.re_n) ? dout_q : ~dout_q;
  always @(posedge sys_clk_i) if (busy_q > 0) busy_q <= busy_q - 1;
  always @(posedge pins_i.we_n) if (!pins_i.ce_n) begin
    if (pins_i.cle && (rdy || pins_i.io inside {8'h70, 8'h71, 8'hff})) begin
      stat_q = pins_i.io inside {8'h70, 8'h71};
      n_q = 0;
      if (pins_i.io inside {8'h10, 8'h11, 8'h15}) pf_q = {pf_q[0], fail_i};
      if (pins_i.io == 8'hff) pf_q = 2'h0;
      // Queued behind any load still running
      if (pins_i.io inside {8'h10, 8'h11, 8'h15, 8'h30, 8'h31, 8'h3f})
        busy_q = busy_q + (slow_i ? 400 : 40);
    end else if (pins_i.ale) begin
      adr_q = {pins_i.io, adr_q[39:8]};
      if (n_q == 0) lo_q = pins_i.io;
      if (n_q == 1) col_q = {pins_i.io[4:0], lo_q};
      n_q++;
    end else if (!pins_i.cle) begin
      mem_q[col_q[3:0]] = pins_i.io;
      col_q++;
    end
  end
  always @(negedge pins_i.re_n) if (!pins_i.ce_n) begin
    dout_q = stat_q ? stat_w : mem_q[col_q[3:0]];
    if (!stat_q) col_q++;
  end
endmodule : ncmo_flash_model

// ==== ncmo_host_tb_top.sv ====
// Self-checking bench for the flash sequencing host controller
`timescale 1ns/100ps
module ncmo_host_tb_top;
  logic                   sys_clk_i, rst_i, en_i, wr_i, rd_i, chk_q, rd_seen, fail_i, slow_i;
  logic [7:0]             addr_i, d;
  logic [31:0]            wdata_i, rdata_o, seed;
  logic [63:0]            exp_q[$], ent;
  logic [12:0]            c;
  logic [16:0]            r;
  int                     bad_count, total_checks;
  ncmo_pkg::ncmo_pin_in_s pin_i;
  ncmo_pkg::ncmo_pins_s   pins_o;
  ncmo_host ncmo_host_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .en_i(en_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pins_o(pins_o));
  ncmo_flash_model ncmo_flash_model_inst (.sys_clk_i(sys_clk_i), .pins_i(pins_o), .fail_i(fail_i),
    .slow_i(slow_i), .pin_o(pin_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic cmp(input string what, input logic [39:0] e, input logic [39:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e & m});
    addr_i <= a;
    rd_i <= 1'b1;
    chk_q <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    chk_q <= 1'b0;
    @(posedge sys_clk_i);
  endtask : rd
  task automatic poll(input logic w);
    int n;
    n = 0;
    do begin
      addr_i <= ncmo_pkg::REG_STAT;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      @(posedge sys_clk_i);
      n++;
    end while ((rdata_o[0] !== 1'b0 || (w && rdata_o[1] !== 1'b1)) && n < 2000);
    if (n >= 2000) begin
      bad_count++;
      wrap_up();
    end
  endtask : poll
  task automatic cmd(input logic [7:0] v);
    wr(ncmo_pkg::REG_CMD, {24'h0, v});
    poll(1'b1);
  endtask : cmd
  task automatic go(input logic [1:0] v);
    wr(ncmo_pkg::REG_GO, {30'h0, v});
    poll(1'b1);
  endtask : go
  task automatic dat(input logic [7:0] v);
    wr(ncmo_pkg::REG_DATA, {24'h0, v});
    poll(1'b0);
  endtask : dat
  task automatic adr5();
    wr(ncmo_pkg::REG_COL, {19'h0, c});
    wr(ncmo_pkg::REG_ROW, {15'h0, r});
    go(ncmo_pkg::GO_ADR5);
  endtask : adr5
  task automatic stat(input logic [7:0] e);
    cmd(ncmo_pkg::C_STATUS);
    go(ncmo_pkg::GO_READ);
    rd(ncmo_pkg::REG_DATA, {24'h0, e}, 32'hff);
  endtask : stat
  // Result watcher: read data stands in the cycle after the strobe
  always @(posedge sys_clk_i) begin
    if (rd_seen) begin
      ent = exp_q.pop_front();
      cmp("rdata", ent[39:0] & 40'hffffffff, {8'h0, rdata_o & ent[63:32]});
    end
    rd_seen <= rd_i & chk_q;
  end
  initial begin
    #300000;
    bad_count++;
    wrap_up();
  end
  initial begin
    {wr_i, rd_i, chk_q, rd_seen, fail_i, slow_i, addr_i, wdata_i} = '0;
    en_i = 1'b1;
    rst_i = 1'b1;
    seed = 32'd53770;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    cmp("idle pins", 4'hf, {pins_o.ce_n, pins_o.we_n, pins_o.re_n, pins_o.io_oe_n});
    rd(ncmo_pkg::REG_CFG, 32'(ncmo_pkg::CFG_RST), 32'h3);
    rd(8'h1c, 32'h0, 32'hffffffff);
    wr(ncmo_pkg::REG_CFG, 32'h3);
    rd(ncmo_pkg::REG_CFG, 32'h3, 32'h3);
    $display("test registers done");
    c = 13'(xs());
    r = 17'(xs());
    d = 8'(xs());
    cmd(8'h80);
    adr5();
    cmp("address", ncmo_flash_model_inst.adr_q, {7'h0, r, 3'h0, c});
    dat(d);
    dat(~d);
    wr(ncmo_pkg::REG_COL, {19'h0, c + 13'h5});
    cmd(8'h85);
    go(ncmo_pkg::GO_ADR2);
    dat(d ^ 8'h5a);
    cmp("column change", ncmo_flash_model_inst.mem_q[4'(c + 13'h5)], d ^ 8'h5a);
    cmd(ncmo_pkg::C_PROG);
    stat(8'he0);
    cmd(8'h00);
    adr5();
    cmd(ncmo_pkg::C_READ_GO);
    go(ncmo_pkg::GO_READ);
    rd(ncmo_pkg::REG_DATA, {24'h0, d}, 32'hff);
    cmd(ncmo_pkg::C_CACHE_RD);
    rd(ncmo_pkg::REG_STAT, 32'h6, 32'h7);
    cmd(ncmo_pkg::C_CACHE_LS);
    rd(ncmo_pkg::REG_STAT, 32'h2, 32'h7);
    $display("test program and cached read done");
    fail_i <= 1'b1;
    cmd(8'h80);
    adr5();
    dat(d);
    cmd(ncmo_pkg::C_PROG_CA);
    fail_i <= 1'b0;
    rd(ncmo_pkg::REG_STAT, 32'h4, 32'h4);
    wr(ncmo_pkg::REG_ROW, {15'h0, r ^ 17'h40});
    wr(ncmo_pkg::REG_GO, 32'(ncmo_pkg::GO_ADR5));
    rd(ncmo_pkg::REG_STAT, 32'h400, 32'h401);
    wr(ncmo_pkg::REG_STAT, 32'hf00);
    cmd(8'h80);
    adr5();
    dat(d);
    cmd(ncmo_pkg::C_PROG);
    stat(8'he2);
    $display("test cached program done");
    wr(ncmo_pkg::REG_CFG, 32'h2);
    for (int o = 0; o < 2; o++) begin
      for (int k = 0; k < 2; k++) begin
        cmd(ncmo_pkg::C_MREAD);
        wr(ncmo_pkg::REG_ROW, {15'h0, 10'(xs()), 1'(k ^ o), r[5:0]});
        go(ncmo_pkg::GO_ADR5);
      end
      rd(ncmo_pkg::REG_STAT, 32'h20, 32'h820);
      cmp("guard", 1'b1, pins_o.wp_n);
      cmd(ncmo_pkg::C_READ_GO);
    end
    for (int k = 0; k < 2; k++) begin
      cmd(ncmo_pkg::C_MREAD);
      wr(ncmo_pkg::REG_ROW, {15'h0, (r & 17'h1ffbf) ^ (k ? 17'h80 : 17'h0)});
      go(ncmo_pkg::GO_ADR5);
    end
    rd(ncmo_pkg::REG_STAT, 32'h800, 32'h800);
    wr(ncmo_pkg::REG_STAT, 32'hf00);
    cmd(ncmo_pkg::C_RESET);
    wr(ncmo_pkg::REG_CFG, 32'h3);
    $display("test multi read done");
    cmd(8'h80);
    adr5();
    dat(d);
    cmd(ncmo_pkg::C_PROG_D0);
    wr(ncmo_pkg::REG_CMD, 32'h90);
    rd(ncmo_pkg::REG_STAT, 32'h208, 32'h208);
    wr(ncmo_pkg::REG_STAT, 32'hf00);
    fail_i <= 1'b1;
    cmd(ncmo_pkg::C_DIN_D1);
    r = r ^ 17'h40;
    adr5();
    dat(d);
    cmd(ncmo_pkg::C_PROG);
    stat(8'he1);
    $display("test multi program done");
    fail_i <= 1'b0;
    slow_i <= 1'b1;
    cmd(8'h80);
    adr5();
    dat(d);
    wr(ncmo_pkg::REG_CMD, 32'(ncmo_pkg::C_PROG));
    wr(ncmo_pkg::REG_DATA, {24'h0, d});
    rd(ncmo_pkg::REG_STAT, 32'h101, 32'h101);
    wr(ncmo_pkg::REG_STAT, 32'hf00);
    poll(1'b0);
    cmp("strobes", 2'h3, {pins_o.we_n, pins_o.re_n});
    wr(ncmo_pkg::REG_CMD, 32'(ncmo_pkg::C_STATUS));
    poll(1'b0);
    wr(ncmo_pkg::REG_GO, 32'(ncmo_pkg::GO_READ));
    poll(1'b0);
    rd(ncmo_pkg::REG_DATA, 32'h80, 32'he0);
    poll(1'b1);
    $display("test busy handling done");
    wrap_up();
  end
endmodule : ncmo_host_tb_top
